// *** icc_pkg.sv ***
// shared constants for the input capture channel
package icc_pkg;
    // ----------------------------------------------------------------
    // register map (byte addresses on the AXI4-Lite port)
    // ----------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_BUF = 8'h04;
    localparam logic [7:0] ADDR_STAT = 8'h08;
    localparam logic [7:0] ADDR_CLR = 8'h0C;
    localparam logic [7:0] ADDR_EN = 8'h10;
    // ----------------------------------------------------------------
    // control register fields
    // ----------------------------------------------------------------
    localparam int CTL_SIDL_BIT = 13;
    localparam int CTL_TSEL_LSB = 10;
    localparam int CTL_CPI_LSB = 5;
    localparam int CTL_OVF_BIT = 4;
    localparam int CTL_BNE_BIT = 3;
    localparam int CTL_MODE_LSB = 0;
    localparam logic [2:0] MODE_RESET = 3'h0;
    localparam logic [2:0] TSEL_RESET = 3'h0;
    localparam logic [1:0] CPI_RESET = 2'h0;
    // ----------------------------------------------------------------
    // mode and timebase codes
    // ----------------------------------------------------------------
    localparam logic [2:0] MODE_OFF = 3'h0;
    localparam logic [2:0] MODE_ANY = 3'h1;
    localparam logic [2:0] MODE_FALL = 3'h2;
    localparam logic [2:0] MODE_RISE = 3'h3;
    localparam logic [2:0] MODE_PRE4 = 3'h4;
    localparam logic [2:0] MODE_PRE16 = 3'h5;
    localparam logic [2:0] MODE_UNUSED = 3'h6;
    localparam logic [2:0] MODE_WAKE = 3'h7;
    localparam logic [2:0] TSEL_T3 = 3'h0;
    localparam logic [2:0] TSEL_T2 = 3'h1;
    localparam logic [2:0] TSEL_T4 = 3'h2;
    localparam logic [2:0] TSEL_T5 = 3'h3;
    localparam logic [2:0] TSEL_T1 = 3'h4;
    localparam logic [2:0] TSEL_PCLK = 3'h7;
    localparam logic [3:0] PRE4_LAST = 4'h3;
    localparam logic [3:0] PRE16_LAST = 4'hF;
    // ----------------------------------------------------------------
    // interrupt events, buffer, bus answers
    // ----------------------------------------------------------------
    localparam int EV_W = 3;
    localparam int EV_CAP = 0;
    localparam int EV_OVF = 1;
    localparam int EV_WAKE = 2;
    localparam logic [2:0] EV_RESET = 3'h0;
    localparam int TB_W = 16;
    localparam int FIFO_PTR_W = 2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** icc_fifo_if.sv ***
// link between the capture logic and its value buffer
`timescale 1ns/1ps
`default_nettype none
interface icc_fifo_if;
    logic push;
    logic [15:0] pushData;
    logic pop;
    logic full;
    logic empty;
    logic [15:0] rdData;
    modport store(input push, input pushData, input pop, output full, output empty,
        output rdData);
    modport user(output push, output pushData, output pop, input full, input empty,
        input rdData);
endinterface
`default_nettype wire

// *** icc_fifo.sv ***
// four-entry buffer of captured timebase values
`timescale 1ns/1ps
`default_nettype none
module icc_fifo
    import icc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // buffer port
    icc_fifo_if.store port
);
    typedef struct packed {
        logic [3:0][TB_W-1:0] mem;
        logic [FIFO_PTR_W:0] wrPtr;
        logic [FIFO_PTR_W:0] rdPtr;
        logic [TB_W-1:0] rdData;
    } icc_fifo_state_s;

    icc_fifo_state_s st_r;
    icc_fifo_state_s st_nxt;
    logic isFull;
    logic isEmpty;

    // extra pointer bit tells full from empty
    assign isEmpty = (st_r.wrPtr == st_r.rdPtr);
    assign isFull = (st_r.wrPtr[FIFO_PTR_W] != st_r.rdPtr[FIFO_PTR_W])
        && (st_r.wrPtr[FIFO_PTR_W-1:0] == st_r.rdPtr[FIFO_PTR_W-1:0]);
    assign port.full = isFull;
    assign port.empty = isEmpty;
    assign port.rdData = st_r.rdData;

    always_comb begin
        st_nxt = st_r;
        // a push into a full buffer is dropped here
        if (port.push && !isFull) begin
            st_nxt.mem[st_r.wrPtr[FIFO_PTR_W-1:0]] = port.pushData;
            st_nxt.wrPtr = st_r.wrPtr + 3'h1;
        end
        // each read removes the oldest entry
        if (port.pop && !isEmpty) begin
            st_nxt.rdData = st_r.mem[st_r.rdPtr[FIFO_PTR_W-1:0]];
            st_nxt.rdPtr = st_r.rdPtr + 3'h1;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule
`default_nettype wire

// *** icc_input_capture.sv ***
// input capture channel with AXI4-Lite register port
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - stop bit halts capture during idle
// - timebase code 111 uses peripheral clock
// - timebase code 100 uses timer one
// - codes 011/010/001/000 pick timers five/four/two/three
// - interrupt every one to four captures
// - capture count ignored in modes 001, 111
// - overflow flag set on buffer overflow
// - not-empty flag shows buffered values
// - mode 111: rising edge wake only
// - mode 101 captures every sixteenth rising edge
// - mode 100 captures every fourth rising edge
// - mode 011 captures every rising edge
// - mode 010 captures every falling edge
// - mode 001 captures both edges
// - modes 000 and 110 disable channel
module icc_input_capture
    import icc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // capture pin and processor power state
    input wire logic capturePin,
    input wire logic cpuIdle,
    input wire logic cpuSleep,
    // timer count values
    input wire logic [TB_W-1:0] timerOneCount,
    input wire logic [TB_W-1:0] timerTwoCount,
    input wire logic [TB_W-1:0] timerThreeCount,
    input wire logic [TB_W-1:0] timerFourCount,
    input wire logic [TB_W-1:0] timerFiveCount,
    // AXI4-Lite write channels
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read channels
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // interrupt
    output logic irq
);
    typedef struct packed {
        logic pinS1, pinS2, pinS3;
        logic stopInIdle;
        logic [2:0] tsel;
        logic [1:0] capsPerInt;
        logic [2:0] mode;
        logic ovf;
        logic [3:0] pre;
        logic [1:0] intCnt;
        logic [TB_W-1:0] pclkCnt;
        logic [EV_W-1:0] status, enable;
        logic irq;
        logic awHeld, wHeld;
        logic [ADDR_W-1:0] awAddr;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic awready, wready, bvalid;
        logic [1:0] bresp;
        logic arready, rdPend;
        logic [ADDR_W-1:0] rdAddr;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } icc_state_s;

    icc_state_s st_r, st_nxt;
    icc_fifo_if fif();
    logic rise, fall, halted, capEv, capInt, wakeEv, ovfEv;
    logic [TB_W-1:0] timebase;
    logic awHs, wHs, arHs, doWrite;
    logic [ADDR_W-1:0] wAddrSel;
    logic [31:0] wDataSel;
    logic [3:0] wStrbSel;
    logic [EV_W-1:0] clrMask;
    logic [15:0] ctrlView;
    icc_fifo u_fifo (
        .clk(clk),
        .reset(reset),
        .port(fif.store)
    );

    // ----------------------------------------------------------------
    // timebase selection
    // ----------------------------------------------------------------
    always_comb begin
        case (st_r.tsel)
            TSEL_PCLK: timebase = st_r.pclkCnt;
            TSEL_T1: timebase = timerOneCount;
            TSEL_T5: timebase = timerFiveCount;
            TSEL_T4: timebase = timerFourCount;
            TSEL_T2: timebase = timerTwoCount;
            TSEL_T3: timebase = timerThreeCount;
            // reserved codes capture zero rather than a stale timer
            default: timebase = '0;
        endcase
    end

    // ----------------------------------------------------------------
    // edge detection and capture
    // ----------------------------------------------------------------
    assign rise = st_r.pinS2 && !st_r.pinS3;
    assign fall = !st_r.pinS2 && st_r.pinS3;
    assign halted = st_r.stopInIdle && cpuIdle;
    assign ctrlView = {2'h0, st_r.stopInIdle, st_r.tsel, 3'h0, st_r.capsPerInt, st_r.ovf,
        !fif.empty, st_r.mode};

    always_comb begin
        st_nxt = st_r;
        capEv = 1'b0;
        capInt = 1'b0;
        wakeEv = 1'b0;
        clrMask = '0;
        // pin passes two flops before the edge stage reads it
        st_nxt.pinS1 = capturePin;
        st_nxt.pinS2 = st_r.pinS1;
        st_nxt.pinS3 = st_r.pinS2;
        st_nxt.pclkCnt = st_r.pclkCnt + 16'h0001;
        if (st_r.mode == MODE_WAKE) begin
            // wake source only; stop bit and count field do not apply
            wakeEv = rise && (cpuSleep || cpuIdle);
        end else if (!halted) begin
            case (st_r.mode)
                MODE_ANY: capEv = rise || fall;
                MODE_FALL: capEv = fall;
                MODE_RISE: capEv = rise;
                MODE_PRE4: begin
                    if (rise) begin
                        capEv = (st_r.pre == PRE4_LAST);
                        st_nxt.pre = capEv ? 4'h0 : st_r.pre + 4'h1;
                    end
                end
                MODE_PRE16: begin
                    if (rise) begin
                        capEv = (st_r.pre == PRE16_LAST);
                        st_nxt.pre = st_r.pre + 4'h1;
                    end
                end
                default: capEv = 1'b0;
            endcase
        end
        if (capEv) begin
            if (st_r.mode == MODE_ANY || st_r.intCnt == st_r.capsPerInt) begin
                capInt = 1'b1;
                st_nxt.intCnt = 2'h0;
            end else begin
                st_nxt.intCnt = st_r.intCnt + 2'h1;
            end
        end
        // a set in the same cycle as the empty-clear wins
        if (ovfEv) begin
            st_nxt.ovf = 1'b1;
        end else if (fif.empty) begin
            st_nxt.ovf = 1'b0;
        end
        // write path: address and data may arrive in either order
        st_nxt.awHeld = st_r.awHeld || awHs;
        st_nxt.wHeld = st_r.wHeld || wHs;
        if (awHs) begin
            st_nxt.awAddr = awaddr;
        end
        if (wHs) begin
            st_nxt.wData = wdata;
            st_nxt.wStrb = wstrb;
        end
        if (st_r.bvalid && bready) begin
            st_nxt.bvalid = 1'b0;
        end
        if (doWrite) begin
            st_nxt.awHeld = 1'b0;
            st_nxt.wHeld = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = RESP_OKAY;
            case (wAddrSel)
                ADDR_CTRL: begin
                    if (wStrbSel[0]) begin
                        st_nxt.mode = wDataSel[CTL_MODE_LSB +: 3];
                        st_nxt.capsPerInt = wDataSel[CTL_CPI_LSB +: 2];
                        // restart counting from zero after a mode write
                        st_nxt.pre = 4'h0;
                        st_nxt.intCnt = 2'h0;
                    end
                    if (wStrbSel[1]) begin
                        st_nxt.tsel = wDataSel[CTL_TSEL_LSB +: 3];
                        st_nxt.stopInIdle = wDataSel[CTL_SIDL_BIT];
                    end
                end
                ADDR_CLR: begin
                    if (wStrbSel[0]) begin
                        clrMask = wDataSel[EV_W-1:0];
                    end
                end
                ADDR_EN: begin
                    if (wStrbSel[0]) begin
                        st_nxt.enable = wDataSel[EV_W-1:0];
                    end
                end
                // buffer and status are read-only; writes are accepted and dropped
                ADDR_BUF, ADDR_STAT: st_nxt.bresp = RESP_OKAY;
                default: st_nxt.bresp = RESP_SLVERR;
            endcase
        end
        st_nxt.awready = !st_nxt.awHeld && !st_nxt.bvalid;
        st_nxt.wready = !st_nxt.wHeld && !st_nxt.bvalid;
        // read path: one cycle to settle the popped value
        if (st_r.rvalid && rready) begin
            st_nxt.rvalid = 1'b0;
        end
        if (arHs) begin
            st_nxt.rdPend = 1'b1;
            st_nxt.rdAddr = araddr;
        end
        if (st_r.rdPend) begin
            st_nxt.rdPend = 1'b0;
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp = RESP_OKAY;
            case (st_r.rdAddr)
                ADDR_CTRL: st_nxt.rdata = {16'h0000, ctrlView};
                ADDR_BUF: st_nxt.rdata = {16'h0000, fif.rdData};
                ADDR_STAT: st_nxt.rdata = {29'h0, st_r.status};
                ADDR_CLR: st_nxt.rdata = 32'h0000_0000;
                ADDR_EN: st_nxt.rdata = {29'h0, st_r.enable};
                default: begin
                    st_nxt.rdata = 32'h0000_0000;
                    st_nxt.rresp = RESP_SLVERR;
                end
            endcase
        end
        st_nxt.arready = !st_nxt.rdPend && !st_nxt.rvalid;
        // sticky events: set wins over a clear in the same cycle
        st_nxt.status = (st_r.status & ~clrMask) | {wakeEv, ovfEv, capInt};
        st_nxt.irq = |(st_nxt.status & st_nxt.enable);
    end

    // ----------------------------------------------------------------
    // bus handshakes and buffer hookup
    // ----------------------------------------------------------------
    assign awHs = awvalid && st_r.awready;
    assign wHs = wvalid && st_r.wready;
    assign arHs = arvalid && st_r.arready;
    assign wAddrSel = st_r.awHeld ? st_r.awAddr : awaddr;
    assign wDataSel = st_r.wHeld ? st_r.wData : wdata;
    assign wStrbSel = st_r.wHeld ? st_r.wStrb : wstrb;
    assign doWrite = (st_r.awHeld || awHs) && (st_r.wHeld || wHs) && !st_r.bvalid;
    assign ovfEv = capEv && fif.full;
    assign fif.push = capEv && !fif.full;
    assign fif.pushData = timebase;
    assign fif.pop = arHs && (araddr == ADDR_BUF) && !fif.empty;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_r <= '0;
            st_r.mode <= MODE_RESET;
            st_r.tsel <= TSEL_RESET;
            st_r.capsPerInt <= CPI_RESET;
            st_r.status <= EV_RESET;
            st_r.enable <= EV_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end
    assign awready = st_r.awready;
    assign wready = st_r.wready;
    assign bvalid = st_r.bvalid;
    assign bresp = st_r.bresp;
    assign arready = st_r.arready;
    assign rvalid = st_r.rvalid;
    assign rdata = st_r.rdata;
    assign rresp = st_r.rresp;
    assign irq = st_r.irq;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence s_mode_write;
        doWrite && (wAddrSel == ADDR_CTRL) && wStrbSel[0];
    endsequence
    sequence s_counters_zero;
        (st_r.pre == 4'h0) && (st_r.intCnt == 2'h0);
    endsequence
    property p_halt;
        @(posedge clk) disable iff (reset) halted && (st_r.mode != MODE_WAKE) |-> !capEv;
    endproperty
    a_halt: assert property (p_halt)
        else $error("capture while halted in idle");
    property p_pclk;
        @(posedge clk) disable iff (reset)
        fif.push && (st_r.tsel == TSEL_PCLK) |-> (fif.pushData == st_r.pclkCnt)
            && (st_r.pclkCnt == 16'($past(st_r.pclkCnt) + 16'h0001));
    endproperty
    a_pclk: assert property (p_pclk)
        else $error("peripheral timebase not captured");
    property p_caps_per_int;
        @(posedge clk) disable iff (reset)
        capEv && (st_r.mode != MODE_ANY) && (st_r.intCnt != st_r.capsPerInt) |-> !capInt;
    endproperty
    a_caps_per_int: assert property (p_caps_per_int)
        else $error("interrupt raised before capture count reached");
    property p_any_int;
        @(posedge clk) disable iff (reset)
        capEv && (st_r.mode == MODE_ANY) |=> st_r.status[EV_CAP];
    endproperty
    a_any_int: assert property (p_any_int)
        else $error("edge mode capture did not flag interrupt");
    property p_ovf;
        @(posedge clk) disable iff (reset) capEv && fif.full |=> st_r.ovf && ctrlView[CTL_OVF_BIT];
    endproperty
    a_ovf: assert property (p_ovf)
        else $error("overflow flag not set");
    property p_bne;
        @(posedge clk) disable iff (reset) fif.push |=> ctrlView[CTL_BNE_BIT] [*1];
    endproperty
    a_bne: assert property (p_bne)
        else $error("not-empty flag low after capture");
    property p_wake;
        @(posedge clk) disable iff (reset) (st_r.mode == MODE_WAKE) |-> !capEv && !capInt;
    endproperty
    a_wake: assert property (p_wake)
        else $error("capture in wake mode");
    property p_pre16;
        @(posedge clk) disable iff (reset)
        (st_r.mode == MODE_PRE16) && (st_r.pre != PRE16_LAST) |-> !capEv;
    endproperty
    a_pre16: assert property (p_pre16)
        else $error("early capture in sixteen-edge mode");
    property p_pre4;
        @(posedge clk) disable iff (reset)
        (st_r.mode == MODE_PRE4) && rise && !halted && (st_r.pre == PRE4_LAST) |-> capEv;
    endproperty
    a_pre4: assert property (p_pre4)
        else $error("fourth edge not captured");
    property p_fall;
        @(posedge clk) disable iff (reset)
        (st_r.mode == MODE_FALL) && !halted |-> capEv == fall;
    endproperty
    a_fall: assert property (p_fall)
        else $error("falling edge capture mismatch");
    property p_off;
        @(posedge clk) disable iff (reset)
        (st_r.mode == MODE_OFF) || (st_r.mode == MODE_UNUSED) |-> !capEv;
    endproperty
    a_off: assert property (p_off)
        else $error("capture while disabled");
    property p_restart;
        @(posedge clk) disable iff (reset) s_mode_write |=> s_counters_zero;
    endproperty
    a_restart: assert property (p_restart)
        else $error("counters not restarted by mode write");
endmodule
`default_nettype wire

// *** icc_pin_model.sv ***
// far-side model: capture pin source and five timer counts
`timescale 1ns/1ps
`default_nettype none
module icc_pin_model
    import icc_pkg::*;
(
    // clock and timer base
    input wire logic clk,
    input wire logic [TB_W-1:0] base,
    // pin and timer counts
    output logic capturePin,
    output logic [TB_W-1:0] timerOneCount,
    output logic [TB_W-1:0] timerTwoCount,
    output logic [TB_W-1:0] timerThreeCount,
    output logic [TB_W-1:0] timerFourCount,
    output logic [TB_W-1:0] timerFiveCount
);
    // timers held still so a captured value names the timer behind it
    assign timerOneCount = base + 16'h1100;
    assign timerTwoCount = base + 16'h2200;
    assign timerThreeCount = base + 16'h3300;
    assign timerFourCount = base + 16'h4400;
    assign timerFiveCount = base + 16'h5500;
    initial capturePin = 1'b0;
    // each level lasts five clocks, above the two-clock minimum
    task automatic drive(input logic v);
        @(posedge clk);
        capturePin <= v;
        repeat (4) @(posedge clk);
    endtask
    task automatic pulse(input int n);
        repeat (n) begin
            drive(1'b1);
            drive(1'b0);
        end
    endtask
endmodule
`default_nettype wire

// *** icc_input_capture_tb_top.sv ***
// self-checking bench for the input capture channel
`timescale 1ns/1ps
`default_nettype none
module icc_input_capture_tb_top import icc_pkg::*; ;
    logic clk, reset, cpuIdle, cpuSleep, capturePin, irq;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd, v0;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rs;
    logic [TB_W-1:0] base, timerOneCount, timerTwoCount, timerThreeCount;
    logic [TB_W-1:0] timerFourCount, timerFiveCount;
    int bad_count = 0;
    int n_checks = 0;
    int cyc = 0;
    int k;
    int tnum [5] = '{3, 2, 4, 5, 1};
    logic [2:0] pm [2] = '{MODE_PRE4, MODE_PRE16};
    int pc [2] = '{4, 16};

    icc_input_capture i_icc_input_capture (.clk, .reset, .capturePin, .cpuIdle, .cpuSleep,
        .timerOneCount, .timerTwoCount, .timerThreeCount, .timerFourCount, .timerFiveCount,
        .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
        .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .irq);
    icc_pin_model i_icc_pin_model (.clk, .base, .capturePin, .timerOneCount, .timerTwoCount,
        .timerThreeCount, .timerFourCount, .timerFiveCount);

    // ----------------------------------------------------------------
    // clock, timeout, checking
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    function automatic logic [31:0] cv(logic [2:0] m, logic [1:0] i, logic [2:0] t, logic s);
        return 32'({s, t, 3'h0, i, 2'h0, m});
    endfunction
    function automatic logic [31:0] tx(input int n);
        return {16'h0, 16'(base + 16'h1100 * n)};
    endfunction

    // ----------------------------------------------------------------
    // bus and pin tasks
    // ----------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        rs = bresp;
        bready <= 1'b0;
    endtask
    task automatic rdRaw(input logic [7:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask
    task automatic rdReg(input logic [7:0] a, input logic [31:0] e);
        rdRaw(a);
        check(rd, e);
        check(32'(rs), 32'(RESP_OKAY));
    endtask
    task automatic pulsePin(input int n);
        i_icc_pin_model.pulse(n);
        repeat (2) @(posedge clk);
    endtask
    task automatic drivePin(input logic v);
        i_icc_pin_model.drive(v);
        repeat (2) @(posedge clk);
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        {reset, cpuIdle, cpuSleep, awvalid, wvalid, bready, arvalid, rready} = 8'h80;
        {awaddr, araddr, wdata, wstrb} = 52'h0000000000F;
        base = 16'h0100;
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        repeat (2) @(posedge clk);
        rdReg(ADDR_CTRL, 32'h0);
        rdReg(ADDR_STAT, 32'h0);
        rdRaw(8'h40);
        check(32'(rs), 32'(RESP_SLVERR));
        wr(8'h40, 32'h7);
        check(32'(rs), 32'(RESP_SLVERR));
        for (k = 0; k < 5; k++) begin
            base <= 16'h0100 + 16'(k);
            wr(ADDR_CTRL, cv(MODE_RISE, 2'h0, 3'(k), 1'b0));
            pulsePin(1);
            rdReg(ADDR_BUF, tx(tnum[k]));
        end
        // free-running peripheral count: two rises ten clocks apart
        wr(ADDR_CTRL, cv(MODE_RISE, 2'h0, TSEL_PCLK, 1'b0));
        pulsePin(2);
        rdRaw(ADDR_BUF);
        v0 = rd;
        rdRaw(ADDR_BUF);
        check(rd - v0, 32'd10);
        wr(ADDR_CTRL, cv(MODE_FALL, 2'h0, 3'h3, 1'b0));
        drivePin(1'b1);
        rdReg(ADDR_CTRL, cv(MODE_FALL, 2'h0, 3'h3, 1'b0));
        drivePin(1'b0);
        rdReg(ADDR_CTRL, cv(MODE_FALL, 2'h0, 3'h3, 1'b0) | 32'h8);
        rdReg(ADDR_BUF, tx(5));
        wr(ADDR_EN, 32'h1);
        wr(ADDR_CLR, 32'h7);
        wr(ADDR_CTRL, cv(MODE_ANY, 2'h3, 3'h3, 1'b0));
        drivePin(1'b1);
        check(32'(irq), 32'h1);
        drivePin(1'b0);
        repeat (2) rdReg(ADDR_BUF, tx(5));
        rdReg(ADDR_CTRL, cv(MODE_ANY, 2'h3, 3'h3, 1'b0));
        for (k = 0; k < 4; k++) begin
            wr(ADDR_CLR, 32'h7);
            wr(ADDR_CTRL, cv(MODE_RISE, 2'(k), 3'h3, 1'b0));
            pulsePin(k);
            check(32'(irq), 32'h0);
            pulsePin(1);
            check(32'(irq), 32'h1);
            repeat (k + 1) rdReg(ADDR_BUF, tx(5));
        end
        wr(ADDR_CLR, 32'h7);
        wr(ADDR_CTRL, cv(MODE_RISE, 2'h0, 3'h0, 1'b0));
        for (k = 0; k < 5; k++) begin
            base <= 16'h0400 + 16'(k);
            pulsePin(1);
        end
        rdReg(ADDR_CTRL, cv(MODE_RISE, 2'h0, 3'h0, 1'b0) | 32'h18);
        rdReg(ADDR_STAT, 32'h3);
        for (k = 0; k < 4; k++) begin
            rdReg(ADDR_BUF, {16'h0, 16'h3700 + 16'(k)});
        end
        repeat (2) @(posedge clk);
        rdReg(ADDR_CTRL, cv(MODE_RISE, 2'h0, 3'h0, 1'b0));
        for (k = 0; k < 2; k++) begin
            wr(ADDR_CTRL, cv(pm[k], 2'h0, 3'h0, 1'b0));
            pulsePin(pc[k] - 1);
            rdReg(ADDR_CTRL, cv(pm[k], 2'h0, 3'h0, 1'b0));
            pulsePin(1);
            rdReg(ADDR_CTRL, cv(pm[k], 2'h0, 3'h0, 1'b0) | 32'h8);
            rdReg(ADDR_BUF, tx(3));
        end
        wr(ADDR_CTRL, cv(MODE_PRE4, 2'h0, 3'h0, 1'b0));
        pulsePin(2);
        wr(ADDR_CTRL, cv(MODE_PRE4, 2'h0, 3'h0, 1'b0));
        pulsePin(3);
        rdReg(ADDR_CTRL, cv(MODE_PRE4, 2'h0, 3'h0, 1'b0));
        pulsePin(1);
        rdReg(ADDR_BUF, tx(3));
        cpuIdle <= 1'b1;
        wr(ADDR_CTRL, cv(MODE_RISE, 2'h0, 3'h0, 1'b1));
        pulsePin(1);
        rdReg(ADDR_CTRL, cv(MODE_RISE, 2'h0, 3'h0, 1'b1));
        wr(ADDR_CTRL, cv(MODE_RISE, 2'h0, 3'h0, 1'b0));
        pulsePin(1);
        rdReg(ADDR_BUF, tx(3));
        cpuIdle <= 1'b0;
        for (k = 0; k < 2; k++) begin
            wr(ADDR_CTRL, cv(k == 0 ? MODE_OFF : MODE_UNUSED, 2'h0, 3'h0, 1'b0));
            pulsePin(2);
            rdReg(ADDR_CTRL, cv(k == 0 ? MODE_OFF : MODE_UNUSED, 2'h0, 3'h0, 1'b0));
        end
        // wake mode: raise, mask, clear, then show a fall is not an event
        wr(ADDR_CLR, 32'h7);
        wr(ADDR_EN, 32'h4);
        cpuSleep <= 1'b1;
        wr(ADDR_CTRL, cv(MODE_WAKE, 2'h3, 3'h0, 1'b1));
        drivePin(1'b1);
        check(32'(irq), 32'h1);
        rdReg(ADDR_STAT, 32'h4);
        rdReg(ADDR_CTRL, cv(MODE_WAKE, 2'h3, 3'h0, 1'b1));
        wr(ADDR_EN, 32'h0);
        check(32'(irq), 32'h0);
        wr(ADDR_CLR, 32'h7);
        drivePin(1'b0);
        rdReg(ADDR_STAT, 32'h0);
        cpuSleep <= 1'b0;
        // awake and not idle: a rising edge must not wake
        drivePin(1'b1);
        rdReg(ADDR_STAT, 32'h0);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        repeat (2) @(posedge clk);
        rdReg(ADDR_CTRL, 32'h0);
        finish_test();
    end
endmodule
`default_nettype wire
